// ---- core/srw_supervisor.sv ----
// srw_supervisor: reset generator with supply, manual-clear and watchdog sources.
// assumes i_supply_ok comes from an external comparator, synchronous to i_ref_clk,
// and that the kick line level is resolved by the bench from o_kick_drive/o_kick_oe.
`timescale 1ns/10ps

// Notes on behaviour
// - after supply good, hold reset a full hold interval, then release
// - supply-ok drop asserts reset once it outlasts the glitch count
// - every reset lasts at least one full hold interval
// - supply drop restarts the hold timer from zero
// - active-high reset output is always the complement of active-low
// - manual clear low holds reset; one more hold interval after release
// - switch bounce restarts hold; release timed from last rising edge
// - open manual clear input reads high, never requests reset
// - no kick change for the deadline period asserts reset
// - watchdog count cleared by reset or any kick edge
// - kick pulses of 50 ns are seen as valid edges
// - watchdog held at zero during reset, counts once released
// - floating kick input disables the watchdog
// - weak driver low for first 7/8 of period, high last 1/8
// - floating kick: internal driver edge clears watchdog before expiry
// - brief supply-low dips are ignored
// - watchdog expiry gives one hold-interval reset, then counting resumes
module srw_supervisor
  import srw_pkg::*;
#(
  parameter int unsigned HOLD_COUNT = HOLD_CYCLES, // hold interval in cycles
  parameter int unsigned DEADLINE_COUNT = DEADLINE_CYCLES, // kick deadline in cycles
  parameter int unsigned GLITCH_COUNT = GLITCH_CYCLES // ignored supply dip in cycles
)(
  input wire logic i_ref_clk, // 200 MHz reference clock
  input wire logic i_sys_rst, // sync reset, active high
  input wire logic i_supply_ok, // supply above threshold, active high
  input wire logic i_manual_clear_in_n, // manual clear, active low
  input wire logic i_activity_kick_in, // resolved kick line level
  output logic o_sys_rst_n, // system reset, active low
  output logic o_sys_rst, // system reset, active high
  output logic o_kick_drive, // weak internal kick driver level
  output logic o_kick_oe // weak driver enable, always high
);

  // =========================================================
  // elaboration checks
  // =========================================================
  // refused at elaboration, not at run time
  if (HOLD_COUNT < 2) begin : g_hold_check
    $error("srw_supervisor: hold count below two cycles");
  end
  // the weak driver needs whole eighths of the deadline
  if (DEADLINE_COUNT < EIGHTHS * 2) begin : g_deadline_check
    $error("srw_supervisor: deadline count below sixteen cycles");
  end
  // the dip counter saturates one above the glitch count
  if (GLITCH_COUNT >= (1 << GLITCH_W) - 1) begin : g_glitch_check
    $error("srw_supervisor: glitch count too wide");
  end
  if (KICK_MIN_CYCLES < 1) begin : g_kick_check
    $error("srw_supervisor: kick pulse below one cycle");
  end

  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_COUNT - 1);
  localparam logic [CNT_W-1:0] DEADLINE_LAST = CNT_W'(DEADLINE_COUNT - 1);
  localparam logic [CNT_W-1:0] DRIVE_HIGH_AT =
    CNT_W'((DEADLINE_COUNT / EIGHTHS) * DRIVE_LOW_EIGHTHS);
  localparam logic [GLITCH_W-1:0] GLITCH_LAST = GLITCH_W'(GLITCH_COUNT);
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
  localparam logic [GLITCH_W-1:0] DIP_ONE = 16'h0001;
  // reset asserted, clear synchroniser resting at the pull-up level
  localparam srw_main_state_type RESET_ST = '{
    state: SRW_ST_HOLD,
    hold_cnt: '0,
    wd_cnt: '0,
    dip_cnt: '0,
    clr_sync: '{sync1: 1'b1, sync2: 1'b1, last: 1'b1},
    rst_n: 1'b0,
    rst: 1'b1,
    kick_drive: 1'b0,
    kick_oe: 1'b1
  };

  srw_main_state_type st_ff;
  srw_main_state_type nxt_st;
  logic kick_edge;
  logic supply_bad;
  logic clear_low;

  // =========================================================
  // kick edge detector
  // =========================================================
  // a 50 ns pulse spans ten clocks, far above the two the sync needs
  srw_kick_edge u_kick_edge (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_level(i_activity_kick_in),
    .o_level(),
    .o_edge(kick_edge)
  );

  // =========================================================
  // next state
  // =========================================================
  always_comb begin
    nxt_st = st_ff;
    // manual clear synchroniser; first stage read only by second
    nxt_st.clr_sync.sync1 = i_manual_clear_in_n;
    nxt_st.clr_sync.sync2 = st_ff.clr_sync.sync1;
    nxt_st.clr_sync.last = st_ff.clr_sync.sync2;
    clear_low = ~st_ff.clr_sync.sync2;

    // dips shorter than the glitch window never reach the reset logic
    if (i_supply_ok) begin
      nxt_st.dip_cnt = '0;
    end else if (st_ff.dip_cnt <= GLITCH_LAST) begin
      nxt_st.dip_cnt = st_ff.dip_cnt + DIP_ONE;
    end
    supply_bad = ~i_supply_ok && (st_ff.dip_cnt >= GLITCH_LAST);

    case (st_ff.state)
      SRW_ST_HOLD: begin
        nxt_st.wd_cnt = '0;
        if (supply_bad || clear_low) begin
          // every bounce restarts the hold count
          nxt_st.hold_cnt = '0;
        end else if (st_ff.hold_cnt >= HOLD_LAST) begin
          nxt_st.state = SRW_ST_RUN;
          nxt_st.hold_cnt = '0;
        end else begin
          nxt_st.hold_cnt = st_ff.hold_cnt + CNT_ONE;
        end
      end
      SRW_ST_RUN: begin
        nxt_st.hold_cnt = '0;
        if (supply_bad || clear_low) begin
          nxt_st.state = SRW_ST_HOLD;
          nxt_st.wd_cnt = '0;
        end else if (st_ff.wd_cnt >= DEADLINE_LAST) begin
          nxt_st.state = SRW_ST_HOLD;
          nxt_st.wd_cnt = '0;
        end else if (kick_edge) begin
          nxt_st.wd_cnt = '0;
        end else begin
          nxt_st.wd_cnt = st_ff.wd_cnt + CNT_ONE;
        end
      end
      default: begin
        nxt_st.state = SRW_ST_HOLD;
        nxt_st.hold_cnt = '0;
        nxt_st.wd_cnt = '0;
      end
    endcase

    nxt_st.rst_n = (nxt_st.state == SRW_ST_RUN);
    nxt_st.rst = ~nxt_st.rst_n;
    // weak driver: low for 7/8, high for last 1/8; its rise is a kick
    // edge when the line floats, clearing the count near 1.4 s
    nxt_st.kick_drive = (nxt_st.wd_cnt >= DRIVE_HIGH_AT);
    // host overrides the weak driver, so it never lets go of the line
    nxt_st.kick_oe = 1'b1;
  end

  // =========================================================
  // state register
  // =========================================================
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      st_ff <= RESET_ST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_sys_rst_n = st_ff.rst_n;
  assign o_sys_rst = st_ff.rst;
  assign o_kick_drive = st_ff.kick_drive;
  assign o_kick_oe = st_ff.kick_oe;

endmodule : srw_supervisor

// ---- core/srw_pkg.sv ----
// srw_pkg: constants and types for the supervisor reset watchdog.
// assumes a 200 MHz reference clock; all times converted to cycles here.
package srw_pkg;

  // =========================================================
  // timing
  // =========================================================
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam longint unsigned HOLD_INTERVAL_MS = 200;
  localparam longint unsigned KICK_DEADLINE_MS = 1600;
  localparam longint unsigned KICK_MIN_NS = 50;
  localparam longint unsigned SUPPLY_GLITCH_US = 15;
  localparam longint unsigned PS_PER_NS = 1000;
  localparam longint unsigned PS_PER_US = 1000000;
  localparam longint unsigned PS_PER_MS = 1000000000;
  localparam int unsigned HOLD_CYCLES =
    int'((HOLD_INTERVAL_MS * PS_PER_MS) / CLK_PERIOD_PS);
  localparam int unsigned DEADLINE_CYCLES =
    int'((KICK_DEADLINE_MS * PS_PER_MS) / CLK_PERIOD_PS);
  // shortest kick pulse in cycles, rounded up
  localparam int unsigned KICK_MIN_CYCLES =
    int'((KICK_MIN_NS * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  // supply dip ignored up to this many cycles, rounded down
  localparam int unsigned GLITCH_CYCLES =
    int'((SUPPLY_GLITCH_US * PS_PER_US) / CLK_PERIOD_PS);
  localparam int unsigned CNT_W = 32;
  localparam int unsigned GLITCH_W = 16;
  localparam int unsigned EIGHTHS = 8;
  localparam int unsigned DRIVE_LOW_EIGHTHS = 7;

  // =========================================================
  // types
  // =========================================================
  typedef enum logic [1:0] {
    SRW_ST_HOLD,
    SRW_ST_RUN
  } srw_state_type;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic last;
  } srw_sync_type;

  typedef struct packed {
    srw_sync_type sync;
    logic edge_seen;
  } srw_edge_state_type;

  typedef struct packed {
    srw_state_type state;
    logic [CNT_W-1:0] hold_cnt;
    logic [CNT_W-1:0] wd_cnt;
    logic [GLITCH_W-1:0] dip_cnt;
    srw_sync_type clr_sync;
    logic rst_n;
    logic rst;
    logic kick_drive;
    // weak driver enable, registered so the output comes from a flop
    logic kick_oe;
  } srw_main_state_type;

endpackage : srw_pkg

// ---- core/srw_kick_edge.sv ----
// srw_kick_edge: synchronises one input and flags any change on it.
// assumes input synchronous-capable pulses at least two clocks wide.
`timescale 1ns/10ps
module srw_kick_edge
  import srw_pkg::*;
(
  input wire logic i_ref_clk, // reference clock
  input wire logic i_sys_rst, // sync reset, active high
  input wire logic i_level, // raw level
  output logic o_level, // synchronised level
  output logic o_edge // one-cycle pulse on any change
);

  srw_edge_state_type st_ff;
  srw_edge_state_type nxt_st;

  // =========================================================
  // next state
  // =========================================================
  always_comb begin
    nxt_st = st_ff;
    // first stage feeds only the second stage
    nxt_st.sync.sync1 = i_level;
    nxt_st.sync.sync2 = st_ff.sync.sync1;
    nxt_st.sync.last = st_ff.sync.sync2;
    nxt_st.edge_seen = st_ff.sync.sync2 ^ st_ff.sync.last;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_level = st_ff.sync.last;
  assign o_edge = st_ff.edge_seen;

endmodule : srw_kick_edge

// ---- tb/srw_supervisor_chk.sv ----
// srw_supervisor_chk: port checks for srw_supervisor
// assumes a bind onto srw_supervisor with the same counts
`timescale 1ns/10ps
module srw_supervisor_chk #(
  parameter int unsigned HOLD_COUNT = 100,
  parameter int unsigned DEADLINE_COUNT = 800
)(
  input wire logic i_ref_clk, // clock
  input wire logic i_sys_rst, // sync reset
  input wire logic i_supply_ok, // supply good
  input wire logic i_manual_clear_in_n, // manual clear
  input wire logic i_activity_kick_in, // kick line
  input wire logic o_sys_rst_n, // reset, low
  input wire logic o_sys_rst, // reset, high
  input wire logic o_kick_drive, // weak drive level
  input wire logic o_kick_oe // weak drive enable
);
  localparam int DRV_LO = DEADLINE_COUNT / 8 * 7 - 4;
  localparam int DRV_HI = DEADLINE_COUNT / 8 * 7 + 8;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  localparam logic [31:0] ONE = 32'h0000_0001;
  logic [31:0] low_cnt_ff, quiet_cnt_ff, idle_cnt_ff;
  logic last_kick_ff;
  // ============================================
  // helper counters
  // ============================================
  // idle count leads the design by the kick sync delay
  always_ff @(posedge i_ref_clk) begin
    last_kick_ff <= i_activity_kick_in;
    low_cnt_ff <= (o_sys_rst_n || i_sys_rst) ? ZERO : low_cnt_ff + ONE;
    quiet_cnt_ff <= (i_sys_rst || !i_supply_ok || !i_manual_clear_in_n) ? ZERO : quiet_cnt_ff + ONE;
    idle_cnt_ff <= (!o_sys_rst_n || i_activity_kick_in != last_kick_ff) ? ZERO : idle_cnt_ff + ONE;
  end
  // ============================================
  // assertions
  // ============================================
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);
  a_rst_inverse: assert property (o_sys_rst == !o_sys_rst_n)
    else $error("reset outputs not complementary");
  a_supply_drop: assert property (!i_supply_ok [*5] |-> ##[0:4] !o_sys_rst_n)
    else $error("supply loss did not assert reset");
  a_clear_hold: assert property (!i_manual_clear_in_n [*2] |-> ##[0:4] !o_sys_rst_n)
    else $error("manual clear did not assert reset");
  a_min_hold: assert property ($rose(o_sys_rst_n) |-> low_cnt_ff >= HOLD_COUNT)
    else $error("reset pulse shorter than hold interval");
  a_release_quiet: assert property ($rose(o_sys_rst_n) |-> quiet_cnt_ff >= HOLD_COUNT)
    else $error("release too soon after last source");
  a_wd_deadline: assert property (o_sys_rst_n |-> idle_cnt_ff <= DEADLINE_COUNT + 8)
    else $error("watchdog missed its deadline");
  a_wd_not_early: assert property ($fell(o_sys_rst_n) && quiet_cnt_ff > 8 |->
    idle_cnt_ff >= DEADLINE_COUNT - 4)
    else $error("watchdog reset too early");
  a_drive_late: assert property ($rose(o_kick_drive) |-> idle_cnt_ff inside {[DRV_LO:DRV_HI]})
    else $error("weak drive rose outside last eighth");
  a_drive_in_rst: assert property (!o_sys_rst_n [*3] |-> !o_kick_drive)
    else $error("weak drive high during reset");
  a_oe_on: assert property (o_kick_oe)
    else $error("weak drive disabled");
  c_release: cover property ($rose(o_sys_rst_n));
  c_drive: cover property ($rose(o_kick_drive));
  c_wd_reset: cover property ($fell(o_sys_rst_n) && quiet_cnt_ff > 8);
endmodule : srw_supervisor_chk

// ---- tb/srw_host_model.sv ----
// srw_host_model: host kick pin and clear switch with pull-up
// assumes the bench drives its controls after rising edges
`timescale 1ns/10ps
module srw_host_model (
  input wire logic i_host_oe, // host drives kick line
  input wire logic i_host_lvl, // host kick level
  input wire logic i_press, // switch closed
  input wire logic i_weak_lvl, // device weak drive
  input wire logic i_weak_oe, // device weak enable
  output logic o_kick_line, // resolved kick line
  output logic o_clear_n // resolved clear line
);
  // strong host beats weak driver; released line follows it
  assign o_kick_line = i_host_oe ? i_host_lvl : (i_weak_oe ? i_weak_lvl : 1'b0);
  assign o_clear_n = i_press ? 1'b0 : 1'b1;
endmodule : srw_host_model

// ---- tb/srw_supervisor_test.sv ----
// srw_supervisor_test: scenario bench for srw_supervisor
// assumes short counts: hold 100, deadline 800, glitch 4
`timescale 1ns/10ps
module srw_supervisor_test;
  localparam int HOLD = 100;
  localparam int DL = 800;
  logic clk = 0, rst = 1, ok = 1, host_oe = 0, host_lvl = 0, press = 0, fell = 0;
  logic line, clr_n, rst_n, rst_h, drv, oe;
  int bad_count = 0, checked = 0, n;
  srw_supervisor #(.HOLD_COUNT(HOLD), .DEADLINE_COUNT(DL), .GLITCH_COUNT(4)) dut (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_supply_ok(ok), .i_manual_clear_in_n(clr_n),
    .i_activity_kick_in(line), .o_sys_rst_n(rst_n), .o_sys_rst(rst_h),
    .o_kick_drive(drv), .o_kick_oe(oe));
  srw_host_model host (.i_host_oe(host_oe), .i_host_lvl(host_lvl), .i_press(press),
    .i_weak_lvl(drv), .i_weak_oe(oe), .o_kick_line(line), .o_clear_n(clr_n));
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(negedge rst_n) fell = 1'b1;
  // ============================================
  // helpers
  // ============================================
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc
  // level read mid-cycle, clear of the edge that launches it
  task automatic wait_lvl(input logic v, output int c);
    c = 0;
    @(negedge clk);
    while (rst_n !== v && c < 5000) begin
      @(negedge clk);
      c++;
    end
    @(posedge clk);
    c++;
  endtask : wait_lvl
  task automatic cmp(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp
  task automatic cmp_rng(input string what, input int lo, input int hi, input int got);
    checked++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : cmp_rng
  task automatic stop_test;
    if (bad_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  // ============================================
  // scenarios
  // ============================================
  task automatic t_power_on;
    rst <= 0;
    wait_lvl(1, n);
    cmp_rng("power-on hold", HOLD, HOLD + 8, n);
    cmp("reset low out", 1'b1, rst_n);
    cmp("inverse out", 1'b0, rst_h);
  endtask : t_power_on
  task automatic t_float;
    fell = 0;
    cyc(3 * DL);
    cmp("float reset", 1'b0, fell);
  endtask : t_float
  task automatic t_kick;
    fell = 0;
    host_oe <= 1;
    host_lvl <= 1'b1;
    cyc(10);
    host_lvl <= 0;
    repeat (4) begin
      cyc(590);
      host_lvl <= 1;
      cyc(10);
      host_lvl <= 0;
    end
    cmp("kick reset", 1'b0, fell);
  endtask : t_kick
  task automatic t_expire;
    // let the last kick pulse end before the level is set and left
    cyc(10);
    host_lvl <= 1;
    wait_lvl(0, n);
    cmp_rng("wd deadline", DL, DL + 10, n);
    host_lvl <= 0;
    wait_lvl(1, n);
    cmp_rng("wd pulse", HOLD, HOLD + 10, n);
    wait_lvl(0, n);
    cmp_rng("wd restart", DL, DL + 10, n);
    wait_lvl(1, n);
    host_oe <= 0;
    cyc(20);
  endtask : t_expire
  task automatic t_supply;
    fell = 0;
    ok <= 0;
    cyc(4);
    ok <= 1;
    cyc(20);
    cmp("short dip", 1'b0, fell);
    ok <= 0;
    cyc(20);
    cmp("dip reset", 1'b0, rst_n);
    ok <= 1;
    cyc(50);
    ok <= 0;
    cyc(20);
    ok <= 1;
    wait_lvl(1, n);
    cmp_rng("brownout hold", HOLD, HOLD + 8, n);
  endtask : t_supply
  task automatic t_manual;
    press <= 1;
    cyc(30);
    cmp("clear low", 1'b0, rst_n);
    repeat (3) begin
      press <= 0;
      cyc(3);
      press <= 1;
      cyc(3);
    end
    press <= 0;
    wait_lvl(1, n);
    cmp_rng("clear hold", HOLD, HOLD + 8, n);
  endtask : t_manual
  initial begin
    cyc(8);
    t_power_on();
    t_float();
    t_kick();
    t_expire();
    t_supply();
    t_manual();
    stop_test();
  end
  initial begin
    cyc(20000);
    bad_count++;
    stop_test();
  end
endmodule : srw_supervisor_test
bind srw_supervisor srw_supervisor_chk #(.HOLD_COUNT(HOLD_COUNT),
  .DEADLINE_COUNT(DEADLINE_COUNT)) u_chk (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
  .i_supply_ok(i_supply_ok), .i_manual_clear_in_n(i_manual_clear_in_n),
  .i_activity_kick_in(i_activity_kick_in), .o_sys_rst_n(o_sys_rst_n),
  .o_sys_rst(o_sys_rst), .o_kick_drive(o_kick_drive), .o_kick_oe(o_kick_oe));
